// >>> src/sfpm_pkg.sv
package sfpm_pkg;

   // =====================================================
   // Modes and states
   typedef enum logic {
      SFPM_MODE0,
      SFPM_MODE3
   } sfpm_mode_t;

   typedef enum logic [1:0] {
      SFPM_ST_POR,
      SFPM_ST_STANDBY,
      SFPM_ST_ACTIVE
   } sfpm_state_t;

   // =====================================================
   // Timing
   localparam int SFPM_CLK_PERIOD_PS = 5000;
   localparam int SFPM_PUW_MS = 3;
   localparam longint SFPM_PUW_PS = longint'(SFPM_PUW_MS) * 64'h0000_0000_3B9A_CA00;
   localparam int SFPM_PUW_CYCLES = int'(SFPM_PUW_PS / SFPM_CLK_PERIOD_PS);
   localparam int SFPM_SYNC_STAGES = 2;
   localparam logic SFPM_RST_MODE = 1'b1;

   // =====================================================
   // Synchronised link pins
   typedef struct packed {
      logic sck;
      logic cs_n;
      logic si;
   } sfpm_pins_t;

   // Idle pin levels: clock high, select high, data low
   localparam sfpm_pins_t SFPM_PINS_IDLE = '{sck: 1'b1, cs_n: 1'b1, si: 1'b0};

   // Transaction status
   typedef struct packed {
      logic in_frame;
      logic mode3;
      logic pe_allowed;
   } sfpm_status_t;

endpackage

// >>> src/sfpm_sync.sv
`timescale 1ns/1ps
module sfpm_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [WIDTH-1:0] i_async,
   input wire logic [WIDTH-1:0] i_rst_val,
   output logic [WIDTH-1:0] o_sync
);

   // =====================================================
   // Two-stage synchroniser
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge i_clk) begin
      meta_reg <= i_async;
   end

   // Reset value comes from a constant port so pins read idle at release
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_sync <= i_rst_val;
      end else begin
         o_sync <= meta_reg;
      end
   end

endmodule

// >>> src/sfpm_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Default to mode 3 after reset
// - Data output undriven after reset release
// - Instructions start only on select fall
// - Select fall samples idle clock, picks mode
// - Power-on reset ignores all commands
// - After power-up sit in standby
// - First program/erase waits startup delay
// - Shift out on fall, capture on rise
module sfpm_top #(
   parameter int PUW_CYCLES = sfpm_pkg::SFPM_PUW_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_por,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_so_data,
   input wire logic i_so_req,
   input wire logic i_pe_req,
   output logic o_so,
   output logic o_so_oe_n,
   output logic o_mode3,
   output logic o_in_frame,
   output logic o_frame_start,
   output logic o_rx_valid,
   output logic o_rx_bit,
   output logic o_so_shift,
   output logic o_standby,
   output logic o_pe_allowed,
   output logic o_pe_start
);

   // =====================================================
   // Pin synchronisation
   sfpm_pkg::sfpm_pins_t pins_sync;
   sfpm_pkg::sfpm_pins_t pins_prev_reg;
   sfpm_pkg::sfpm_state_t state_reg;
   sfpm_pkg::sfpm_status_t stat;
   logic mode3_reg;
   logic pe_ok_reg;
   logic [31:0] puw_cnt_reg;
   logic so_reg;
   logic so_oe_n_reg;
   logic rx_valid_reg;
   logic rx_bit_reg;
   logic so_shift_reg;
   logic frame_start_reg;
   logic pe_pending_reg;
   logic pe_start_reg;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic live;

   sfpm_sync #(
      .WIDTH(3)
   ) u_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async({i_sck, i_cs_n, i_si}),
      .i_rst_val(sfpm_pkg::SFPM_PINS_IDLE),
      .o_sync(pins_sync)
   );

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pins_prev_reg <= sfpm_pkg::SFPM_PINS_IDLE;
      end else begin
         pins_prev_reg <= pins_sync;
      end
   end

   assign live = !i_por;
   assign cs_fall = live && pins_prev_reg.cs_n && !pins_sync.cs_n;
   assign cs_rise = !pins_prev_reg.cs_n && pins_sync.cs_n;
   assign sck_rise = !pins_prev_reg.sck && pins_sync.sck;
   assign sck_fall = pins_prev_reg.sck && !pins_sync.sck;

   // =====================================================
   // Power state
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || i_por) begin
         state_reg <= sfpm_pkg::SFPM_ST_POR;
      end else begin
         case (state_reg)
            sfpm_pkg::SFPM_ST_POR: begin
               state_reg <= sfpm_pkg::SFPM_ST_STANDBY;
            end
            sfpm_pkg::SFPM_ST_STANDBY: begin
               if (cs_fall) begin
                  state_reg <= sfpm_pkg::SFPM_ST_ACTIVE;
               end
            end
            sfpm_pkg::SFPM_ST_ACTIVE: begin
               if (cs_rise) begin
                  state_reg <= sfpm_pkg::SFPM_ST_STANDBY;
               end
            end
            default: begin
               state_reg <= sfpm_pkg::SFPM_ST_POR;
            end
         endcase
      end
   end

   // =====================================================
   // Mode select
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || i_por) begin
         mode3_reg <= sfpm_pkg::SFPM_RST_MODE;
      end else if (state_reg == sfpm_pkg::SFPM_ST_STANDBY && cs_fall) begin
         // Previous sample avoids a clock edge racing the select edge
         mode3_reg <= pins_prev_reg.sck;
      end
   end

   // =====================================================
   // Bit-level data path
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || i_por) begin
         rx_valid_reg <= 1'b0;
         rx_bit_reg <= 1'b0;
         so_shift_reg <= 1'b0;
         frame_start_reg <= 1'b0;
      end else begin
         frame_start_reg <= state_reg == sfpm_pkg::SFPM_ST_STANDBY && cs_fall;
         rx_valid_reg <= state_reg == sfpm_pkg::SFPM_ST_ACTIVE && !cs_rise && sck_rise;
         so_shift_reg <= state_reg == sfpm_pkg::SFPM_ST_ACTIVE && !cs_rise && sck_fall;
         if (state_reg == sfpm_pkg::SFPM_ST_ACTIVE && sck_rise) begin
            rx_bit_reg <= pins_sync.si;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || i_por) begin
         so_reg <= 1'b0;
         so_oe_n_reg <= 1'b1;
      end else if (state_reg != sfpm_pkg::SFPM_ST_ACTIVE || cs_rise) begin
         so_oe_n_reg <= 1'b1;
      end else if (sck_fall && i_so_req) begin
         so_reg <= i_so_data;
         so_oe_n_reg <= 1'b0;
      end else if (!i_so_req) begin
         so_oe_n_reg <= 1'b1;
      end
   end

   // =====================================================
   // Program/erase startup gate
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || i_por) begin
         puw_cnt_reg <= 32'h0000_0000;
         pe_ok_reg <= 1'b0;
      end else if (!pe_ok_reg) begin
         if (puw_cnt_reg >= 32'(PUW_CYCLES - 1)) begin
            pe_ok_reg <= 1'b1;
         end else begin
            puw_cnt_reg <= puw_cnt_reg + 32'h0000_0001;
         end
      end
   end

   // Early requests are held, not dropped
   always_ff @(posedge i_clk) begin
      if (i_sys_rst || i_por) begin
         pe_pending_reg <= 1'b0;
         pe_start_reg <= 1'b0;
      end else begin
         pe_start_reg <= 1'b0;
         if ((i_pe_req || pe_pending_reg) && pe_ok_reg) begin
            pe_pending_reg <= 1'b0;
            pe_start_reg <= 1'b1;
         end else if (i_pe_req) begin
            pe_pending_reg <= 1'b1;
         end
      end
   end

   assign stat = '{in_frame: state_reg == sfpm_pkg::SFPM_ST_ACTIVE, mode3: mode3_reg, pe_allowed: pe_ok_reg};
   assign o_mode3 = stat.mode3;
   assign o_in_frame = stat.in_frame;
   assign o_pe_allowed = stat.pe_allowed;
   assign o_standby = state_reg == sfpm_pkg::SFPM_ST_STANDBY;
   assign o_so = so_reg;
   assign o_so_oe_n = so_oe_n_reg;
   assign o_rx_valid = rx_valid_reg;
   assign o_rx_bit = rx_bit_reg;
   assign o_so_shift = so_shift_reg;
   assign o_frame_start = frame_start_reg;
   assign o_pe_start = pe_start_reg;

   // =====================================================
   // Checks
   mode_reset_a: assert property (@(posedge i_clk) $fell(i_sys_rst) |-> o_mode3)
      else $error("mode not 3 after reset");
   so_hiz_a: assert property (@(posedge i_clk) (i_sys_rst || i_por) |=> o_so_oe_n)
      else $error("output driven after reset");
   start_on_fall_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_in_frame) |-> $past(cs_fall))
      else $error("frame without select fall");
   mode_pick_a: assert property (@(posedge i_clk) disable iff (i_sys_rst || i_por)
      (o_standby && cs_fall) |=> o_mode3 == $past(pins_prev_reg.sck))
      else $error("wrong mode picked");
   por_ignore_a: assert property (@(posedge i_clk) i_por |=> !o_in_frame && !o_rx_valid)
      else $error("activity during power-on reset");
   standby_entry_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $fell(i_por) |-> ##1 o_standby)
      else $error("no standby after power-up");
   pe_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_pe_start |-> $past(pe_ok_reg))
      else $error("program/erase started too early");
   shift_edge_a: assert property (@(posedge i_clk) disable iff (i_sys_rst || i_por)
      $fell(o_so_oe_n) |-> $past(sck_fall))
      else $error("output not on falling edge");
   mode_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst || i_por)
      (o_in_frame && !cs_rise) |=> $stable(o_mode3))
      else $error("mode changed inside frame");

endmodule

// >>> verif/sfpm_host.sv
`timescale 1ns/1ps
// ==========================================
// Host controller model
module sfpm_host #(
   parameter int HALF_NS = 32,
   parameter int SUPPLY_TO_SELECT_NS = 700
) (
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si
);
   initial begin
      o_sck = 1'b1;
      o_cs_n = 1'b1;
      o_si = 1'b0;
   end
   // Clock stands at its idle level outside frames
   task automatic frame(input logic idle, input logic [1:0] bits);
      o_sck = idle;
      #(4 * HALF_NS);
      // Scaled supply-to-select wait before any select
      if ($time < SUPPLY_TO_SELECT_NS) #(SUPPLY_TO_SELECT_NS - $time);
      o_cs_n = 1'b0;
      #(2 * HALF_NS);
      for (int i = 1; i >= 0; i--) begin
         o_sck = 1'b0;
         o_si = bits[i];
         #(HALF_NS);
         o_sck = 1'b1;
         #(HALF_NS);
      end
      o_sck = idle;
      #(2 * HALF_NS);
      o_cs_n = 1'b1;
      // Released line: no stale value left behind
      o_si = ~o_si;
      #(2 * HALF_NS);
   endtask
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module tb;
   localparam int PUW = 20;
   typedef struct packed {logic idle; logic [1:0] bits; logic mode3;} sfpm_row_t;
   logic i_clk = 1'b0, i_sys_rst = 1'b1, i_por = 1'b0, i_so_data = 1'b0, i_so_req = 1'b0, i_pe_req = 1'b0;
   logic sck, cs_n, si, o_so, o_so_oe_n, o_mode3, o_in_frame, o_frame_start, o_rx_valid, o_rx_bit;
   logic o_so_shift, o_standby, o_pe_allowed, o_pe_start;
   int mismatches = 0, comparisons = 0, fs_cnt = 0, sh_cnt = 0, drv_cnt = 0, n, f, s;
   logic [1:0] rx_hist = 2'h0;
   logic frame_prev = 1'b0, mode_prev = 1'b1;
   int hold_bad = 0;
   sfpm_row_t rows [4] = '{'{1'b1, 2'h2, 1'b1}, '{1'b0, 2'h1, 1'b0}, '{1'b1, 2'h0, 1'b1}, '{1'b0, 2'h3, 1'b0}};
   initial forever #2.5 i_clk = ~i_clk;
   sfpm_host HOST (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));
   sfpm_top #(.PUW_CYCLES(PUW)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_por(i_por), .i_sck(sck),
      .i_cs_n(cs_n), .i_si(si), .i_so_data(i_so_data), .i_so_req(i_so_req), .i_pe_req(i_pe_req),
      .o_so(o_so), .o_so_oe_n(o_so_oe_n), .o_mode3(o_mode3), .o_in_frame(o_in_frame),
      .o_frame_start(o_frame_start), .o_rx_valid(o_rx_valid), .o_rx_bit(o_rx_bit), .o_so_shift(o_so_shift),
      .o_standby(o_standby), .o_pe_allowed(o_pe_allowed), .o_pe_start(o_pe_start));
   // ==========================================
   // Monitors
   always @(posedge i_clk) begin
      if (o_frame_start === 1'b1) fs_cnt++;
      if (o_so_shift === 1'b1) sh_cnt++;
      if (o_rx_valid === 1'b1) rx_hist <= {rx_hist[0], o_rx_bit};
      if (o_so_oe_n === 1'b0 && o_so === 1'b1) drv_cnt++;
      // Mode must not move while a frame stays open
      if (frame_prev && o_in_frame === 1'b1 && o_mode3 !== mode_prev) hold_bad++;
      frame_prev = (o_in_frame === 1'b1);
      mode_prev = o_mode3;
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Pulse may be short, so sample every cycle
   task automatic wait_pe(output int k);
      for (k = 0; k < 100 && o_pe_start !== 1'b1; k++) @(negedge i_clk);
      if (k == 100) begin
         mismatches++;
         $display("ERROR %0t no start pulse", $time);
         give_verdict();
      end
   endtask
   // ==========================================
   // Sequence
   initial begin
      repeat (4) @(negedge i_clk);
      i_sys_rst = 1'b0;
      i_pe_req = 1'b1;
      @(negedge i_clk);
      i_pe_req = 1'b0;
      `CHK(o_mode3, 1'b1)
      `CHK(o_so_oe_n, 1'b1)
      @(negedge i_clk);
      `CHK(o_standby, 1'b1)
      wait_pe(n);
      `CHK(n >= PUW - 2, 1'b1)
      `CHK(o_pe_allowed, 1'b1)
      @(negedge i_clk);
      i_pe_req = 1'b1;
      @(negedge i_clk);
      i_pe_req = 1'b0;
      wait_pe(n);
      `CHK(n < 3, 1'b1)
      $display("reset and startup test done");
      foreach (rows[i]) begin
         f = fs_cnt + 1;
         s = sh_cnt;
         HOST.frame(rows[i].idle, rows[i].bits);
         repeat (8) @(negedge i_clk);
         `CHK(fs_cnt, f)
         `CHK(o_mode3, rows[i].mode3)
         `CHK(rx_hist, rows[i].bits)
         `CHK(sh_cnt - s, 2)
         `CHK(o_in_frame, 1'b0)
         `CHK(hold_bad, 0)
         $display("row %0d done", i);
      end
      i_por = 1'b1;
      f = fs_cnt;
      HOST.frame(1'b0, 2'h3);
      `CHK(fs_cnt, f)
      `CHK(o_in_frame, 1'b0)
      `CHK(o_mode3, 1'b1)
      @(negedge i_clk);
      i_por = 1'b0;
      repeat (2) @(negedge i_clk);
      `CHK(o_standby, 1'b1)
      $display("power-on reset test done");
      i_so_req = 1'b1;
      i_so_data = 1'b1;
      HOST.frame(1'b1, 2'h1);
      `CHK(drv_cnt > 0, 1'b1)
      @(negedge i_clk);
      i_so_req = 1'b0;
      repeat (3) @(negedge i_clk);
      `CHK(o_so_oe_n, 1'b1)
      $display("output test done");
      HOST.frame(1'b0, 2'h2);
      @(negedge i_clk);
      `CHK(o_mode3, 1'b0)
      i_sys_rst = 1'b1;
      repeat (4) @(negedge i_clk);
      i_sys_rst = 1'b0;
      @(negedge i_clk);
      `CHK(o_mode3, 1'b1)
      `CHK(o_so_oe_n, 1'b1)
      @(negedge i_clk);
      `CHK(o_standby, 1'b1)
      f = fs_cnt + 1;
      HOST.frame(1'b1, 2'h1);
      repeat (8) @(negedge i_clk);
      `CHK(fs_cnt, f)
      `CHK(rx_hist, 2'h1)
      $display("mid-run reset test done");
      give_verdict();
   end
endmodule
